// ### src/obr_pkg.sv
// package for the option-bits reader: sector layout, register map,
// event bits, flash request carrier and controller states.
// assumes a 32-bit flash word port addressed in bytes.
package obr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // option-bits sector layout
   localparam int          NUM_PAGES       = 8;
   localparam int          TABLE_WORDS     = 16;
   localparam int          FULL_ADDR_W     = 34;
   localparam logic [31:0] OPT_VERSION_OFS = 32'h0000_0080;
   localparam logic [7:0]  VERSION_EXPECT  = 8'h05;
   localparam int          START_FIELD_LSB = 11;
   localparam int          VALID_BIT       = 0;
   localparam int          START_PAD_BITS  = 13;
   localparam logic [1:0]  END_TAIL        = 2'h3;
   localparam logic [31:0] BASE_ALIGN_MASK = 32'hFFFF_E000;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte offsets) and reset values
   localparam logic [7:0]  REG_CTRL        = 8'h00;
   localparam logic [7:0]  REG_OPT_BASE    = 8'h04;
   localparam logic [7:0]  REG_STATUS      = 8'h08;
   localparam logic [7:0]  REG_SEL_START   = 8'h0C;
   localparam logic [7:0]  REG_SEL_END     = 8'h10;
   localparam logic [7:0]  REG_IRQ_STAT    = 8'h14;
   localparam logic [7:0]  REG_IRQ_CLR     = 8'h18;
   localparam logic [7:0]  REG_IRQ_EN      = 8'h1C;
   localparam logic [31:0] OPT_BASE_RESET  = 32'h0000_0000;

   // control register fields
   localparam int          CTRL_SCAN_BIT   = 0;
   localparam int          CTRL_SEL_BIT    = 1;
   localparam int          CTRL_MARK_BIT   = 2;
   localparam int          CTRL_PAGE_LSB   = 4;

   // status register fields
   localparam int          ST_BUSY_BIT     = 0;
   localparam int          ST_LOADED_BIT   = 1;
   localparam int          ST_VER_OK_BIT   = 2;
   localparam int          ST_MASK_LSB     = 8;
   localparam int          ST_VER_LSB      = 16;
   localparam int          ST_START_HI_LSB = 24;
   localparam int          ST_END_HI_LSB   = 26;

   // interrupt event bits
   localparam int          EV_W            = 4;
   localparam int          EV_SCAN_DONE    = 0;
   localparam int          EV_VERSION_BAD  = 1;
   localparam int          EV_PAGE_ERROR   = 2;
   localparam int          EV_MARK_DONE    = 3;

   ////////////////////////////////////////////////////////////////////////////
   // flash request carrier, held until acknowledged
   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } obr_flash_req_type;

   typedef enum {
      OBR_IDLE, OBR_SCAN, OBR_VER, OBR_SEL_A, OBR_SEL_B, OBR_SEL_C,
      OBR_MARK_A, OBR_MARK_B, OBR_MARK_WR
   } obr_state_type;

endpackage

// ### src/obr_table_mem.sv
// small page-table memory: one write port, registered read data.
// assumes a single clock; contents are undefined until written.
module obr_table_mem #(
   parameter int DEPTH  = 16,
   parameter int WIDTH  = 32,
   parameter int ADDR_W = 4
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst_b,
   // write port
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] waddr,
   input  wire logic [WIDTH-1:0]  wdata,
   // read port, data one cycle after the address
   input  wire logic [ADDR_W-1:0] raddr,
   output      logic [WIDTH-1:0]  rdata
);

   logic [WIDTH-1:0] cells [DEPTH];

   // storage is not reset to keep it a plain ram
   always_ff @(posedge clock) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
   end

   // registered read port
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= '0;
      end else begin
         rdata <= cells[raddr];
      end
   end

endmodule

// ### src/obr_reader.sv
// option-bits reader: loads the page table from flash, selects a page to
// configure from and marks pages valid after programming.
// assumes a flash port that acknowledges each held request with one pulse.
// Functional notes
// [R1] at most eight pages per flash block
// [R2] page starts lie on 8 KB boundaries
// [R3] one start per page, one shared version
// [R4] write valid flag only after programming succeeds
// [R5] bit 0: zero valid, one error
// [R6] page n start at 8n, end at 8n+4
// [R7] version byte at 0x80, expected 0x05
// [R8] start field bits 31:11, reserved bits ignored
// [R9] start address: field plus thirteen zero bits
// [R10] end address: stored field plus binary 11
// [R11] option base equals flash option location
// [R12] flash writers never overwrite option sector
// [R13] separate chains use separate pages
// [R14] refuse error page, report configuration error
//
// Strobed register access and the placing of the registers were chosen for this implementation.
module obr_reader (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          rst_b,
   // register port
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output      logic [31:0]                   reg_rdata,
   // flash port
   output      obr_pkg::obr_flash_req_type    flash_out,
   input  wire logic                          flash_ack,
   input  wire logic [31:0]                   flash_rdata,
   // configuration side
   output      logic                          cfg_go,
   output      logic [obr_pkg::FULL_ADDR_W-1:0] cfg_start,
   output      logic [obr_pkg::FULL_ADDR_W-1:0] cfg_end,
   // interrupt
   output      logic                          irq
);
   import obr_pkg::*;

   obr_state_type      state;
   obr_state_type      next_state;
   logic [31:0]        opt_base;
   logic [3:0]         scan_idx;
   logic [2:0]         cmd_page;
   logic [31:0]        sel_start_raw;
   logic [7:0]         version;
   logic               loaded;
   logic [NUM_PAGES-1:0] valid_mask;
   logic [EV_W-1:0]    irq_stat;
   logic [EV_W-1:0]    irq_en;

   ////////////////////////////////////////////////////////////////////////////
   // helper functions
   function automatic logic [31:0] word_addr(input logic [31:0] base,
                                             input logic [3:0]  idx);
      word_addr = base + {26'h0, idx, 2'h0};
   endfunction

   function automatic logic [FULL_ADDR_W-1:0] start_of(input logic [31:0] w);
      start_of = {w[31:START_FIELD_LSB], {START_PAD_BITS{1'b0}}};
   endfunction

   function automatic logic [FULL_ADDR_W-1:0] end_of(input logic [31:0] w);
      end_of = {w, END_TAIL};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   wire wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
   wire wr_base   = reg_wr && (reg_addr == REG_OPT_BASE);
   wire wr_clr    = reg_wr && (reg_addr == REG_IRQ_CLR);
   wire wr_en     = reg_wr && (reg_addr == REG_IRQ_EN);
   wire idle      = (state == OBR_IDLE);
   // commands are ignored while a sequence runs; scan wins over the others
   wire cmd_scan  = wr_ctrl && idle && reg_wdata[CTRL_SCAN_BIT];
   wire cmd_sel   = wr_ctrl && idle && !reg_wdata[CTRL_SCAN_BIT] && reg_wdata[CTRL_SEL_BIT];
   wire cmd_mark  = wr_ctrl && idle && !reg_wdata[CTRL_SCAN_BIT]
                    && !reg_wdata[CTRL_SEL_BIT] && reg_wdata[CTRL_MARK_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // table memory hookup
   logic [31:0] mem_rdata;
   wire  ack_scan  = flash_ack && (state == OBR_SCAN);
   wire  ack_ver   = flash_ack && (state == OBR_VER);
   wire  ack_mark  = flash_ack && (state == OBR_MARK_WR);
   wire  mem_we    = ack_scan || ack_mark;
   // page n start sits at word 2n, its end at word 2n+1
   wire  [3:0] mem_waddr = ack_mark ? {cmd_page, 1'b0} : scan_idx; // R6
   wire  [31:0] mem_wdata = ack_mark ? flash_out.wdata : flash_rdata;
   wire  [3:0] mem_raddr = {cmd_page, (state == OBR_SEL_B)};

   obr_table_mem #(.DEPTH(TABLE_WORDS), .WIDTH(32), .ADDR_W(4)) u_table (
      .clock (clock),
      .rst_b (rst_b),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // page checks
   wire sel_refuse = (state == OBR_SEL_C) && (sel_start_raw[VALID_BIT] || !loaded); // R14
   wire sel_accept = (state == OBR_SEL_C) && !sel_refuse;
   wire mark_refuse = (state == OBR_MARK_A) && !loaded;
   wire ver_bad    = ack_ver && (flash_rdata[7:0] != VERSION_EXPECT); // R7

   // hardware events; set wins over a clear in the same cycle
   wire [EV_W-1:0] events = {ack_mark, (sel_refuse || mark_refuse), ver_bad, ack_ver};

   ////////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         OBR_IDLE: begin
            if (cmd_scan) begin
               next_state = OBR_SCAN;
            end else if (cmd_sel) begin
               next_state = OBR_SEL_A;
            end else if (cmd_mark) begin
               next_state = OBR_MARK_A;
            end
         end
         OBR_SCAN: begin
            // exactly sixteen words: eight start and eight end entries
            if (ack_scan && (scan_idx == 4'(TABLE_WORDS - 1))) begin // R1
               next_state = OBR_VER;
            end
         end
         OBR_VER: begin
            if (ack_ver) begin
               next_state = OBR_IDLE;
            end
         end
         OBR_SEL_A:  next_state = OBR_SEL_B;
         OBR_SEL_B:  next_state = OBR_SEL_C;
         OBR_SEL_C:  next_state = OBR_IDLE;
         OBR_MARK_A: next_state = loaded ? OBR_MARK_B : OBR_IDLE;
         OBR_MARK_B: next_state = OBR_MARK_WR;
         OBR_MARK_WR: begin
            if (ack_mark) begin
               next_state = OBR_IDLE;
            end
         end
         default:    next_state = OBR_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // flash request: one idle cycle after each acknowledge before the next
   wire flash_state = (state == OBR_SCAN) || (state == OBR_VER) || (state == OBR_MARK_WR);
   wire issue       = flash_state && !flash_out.req && !flash_ack;
   wire [31:0] next_flash_addr =
      (state == OBR_VER)     ? opt_base + OPT_VERSION_OFS :        // R7 R3
      (state == OBR_MARK_WR) ? word_addr(opt_base, {cmd_page, 1'b0}) : // R6 R11
                               word_addr(opt_base, scan_idx);          // R6 R11

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         flash_out <= '0;
      end else if (flash_ack) begin
         flash_out.req <= 1'b0;
         flash_out.we  <= 1'b0;
      end else if (issue) begin
         flash_out.req   <= 1'b1;
         flash_out.we    <= (state == OBR_MARK_WR); // R4
         flash_out.addr  <= next_flash_addr;
         // clear only the flag, keep the stored field and reserved bits
         flash_out.wdata <= sel_start_raw & ~32'h0000_0001; // R4 R5
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer state, scan index and command page
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state    <= OBR_IDLE;
         scan_idx <= '0;
         cmd_page <= '0;
      end else begin
         state <= next_state;
         if (cmd_scan) begin
            scan_idx <= '0;
         end else if (ack_scan) begin
            scan_idx <= scan_idx + 4'h1;
         end
         if (cmd_sel || cmd_mark) begin
            cmd_page <= reg_wdata[CTRL_PAGE_LSB +: 3];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // table summary: one version shared by all pages, per-page valid flags
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         loaded     <= 1'b0;
         version    <= '0;
         valid_mask <= '0;
      end else begin
         if (cmd_scan) begin
            loaded <= 1'b0;
         end else if (ack_ver) begin
            loaded  <= 1'b1;
            version <= flash_rdata[7:0]; // R3 R7
         end
         if (mem_we && !mem_waddr[0]) begin
            valid_mask[mem_waddr[3:1]] <= !mem_wdata[VALID_BIT]; // R5
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // page selection; reserved bits of the start word never reach the output
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sel_start_raw <= '0;
         cfg_go        <= 1'b0;
         cfg_start     <= '0;
         cfg_end       <= '0;
      end else begin
         cfg_go <= sel_accept; // R14
         if ((state == OBR_SEL_B) || (state == OBR_MARK_B)) begin
            sel_start_raw <= mem_rdata;
         end
         if (sel_accept) begin
            cfg_start <= start_of(sel_start_raw); // R8 R9 R2
            cfg_end   <= end_of(mem_rdata);       // R10
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers: base, interrupt enable and sticky status
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         opt_base <= OPT_BASE_RESET;
         irq_en   <= '0;
         irq_stat <= '0;
         irq      <= 1'b0;
      end else begin
         if (wr_base) begin
            // the option sector itself starts on an 8 KB boundary
            opt_base <= reg_wdata & BASE_ALIGN_MASK; // R11 R2
         end
         if (wr_en) begin
            irq_en <= reg_wdata[EV_W-1:0];
         end
         irq_stat <= (irq_stat & ~(wr_clr ? reg_wdata[EV_W-1:0] : '0)) | events;
         irq      <= |(irq_stat & irq_en);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped and write-only offsets read as zero
   wire [31:0] status_word = {4'h0, cfg_end[FULL_ADDR_W-1 -: 2], cfg_start[FULL_ADDR_W-1 -: 2],
                              version, valid_mask, 5'h0,
                              (version == VERSION_EXPECT), loaded, !idle};
   wire [31:0] next_rdata =
      (reg_addr == REG_CTRL)      ? {25'h0, cmd_page, 4'h0} :
      (reg_addr == REG_OPT_BASE)  ? opt_base :
      (reg_addr == REG_STATUS)    ? status_word :
      (reg_addr == REG_SEL_START) ? cfg_start[31:0] :
      (reg_addr == REG_SEL_END)   ? cfg_end[31:0] :
      (reg_addr == REG_IRQ_STAT)  ? {28'h0, irq_stat} :
      (reg_addr == REG_IRQ_EN)    ? {28'h0, irq_en} : 32'h0;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_start_align: assert property ( // R2
      @(posedge clock) disable iff (!rst_b)
      cfg_go |-> (cfg_start[START_PAD_BITS-1:0] == '0))
      else $error("selected start not on an 8 KB boundary");

   chk_end_tail: assert property ( // R10
      @(posedge clock) disable iff (!rst_b)
      cfg_go |-> (cfg_end[1:0] == END_TAIL))
      else $error("end address tail is not binary 11");

   chk_field_used: assert property ( // R8
      @(posedge clock) disable iff (!rst_b)
      cfg_go |-> (cfg_start[FULL_ADDR_W-1:START_PAD_BITS] == $past(sel_start_raw[31:11])))
      else $error("start field decoded from the wrong bits");

   chk_error_refused: assert property ( // R14
      @(posedge clock) disable iff (!rst_b)
      ((state == OBR_SEL_C) && sel_start_raw[VALID_BIT]) |=> (!cfg_go && irq_stat[EV_PAGE_ERROR]))
      else $error("error page was not refused");

   chk_mark_write: assert property ( // R4
      @(posedge clock) disable iff (!rst_b)
      (flash_out.req && flash_out.we) |-> ((state == OBR_MARK_WR)
         && !flash_out.wdata[VALID_BIT] && $past(loaded, 3)))
      else $error("flag write outside a mark sequence");

   chk_mark_addr: assert property ( // R6
      @(posedge clock) disable iff (!rst_b)
      (flash_out.req && flash_out.we) |-> (flash_out.addr == opt_base + {26'h0, cmd_page, 3'h0}))
      else $error("flag written to the wrong sector offset");

   chk_version_addr: assert property ( // R7
      @(posedge clock) disable iff (!rst_b)
      ((state == OBR_VER) && flash_out.req) |-> (flash_out.addr == opt_base + OPT_VERSION_OFS))
      else $error("version read from the wrong offset");

   chk_scan_bound: assert property ( // R1
      @(posedge clock) disable iff (!rst_b)
      ((state == OBR_SCAN) && flash_out.req) |-> (flash_out.addr - opt_base < 32'h0000_0040))
      else $error("table scan ran past page seven");

   chk_irq_level: assert property (
      @(posedge clock) disable iff (!rst_b)
      ((irq_stat & irq_en) != '0) |=> irq)
      else $error("enabled event did not raise the interrupt");

endmodule

// ### testbench/obr_flash_model.sv
// flash model: word memory holding the option-bits sector behind the reader.
// assumes the reader holds each request until it sees the acknowledge pulse.
module obr_flash_model #(
   parameter logic [31:0] BASE = 32'h0001_2000
) (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_b,
   // request side
   input  wire obr_pkg::obr_flash_req_type flash_out,
   input  wire logic                       slow,
   output      logic                       flash_ack,
   output      logic [31:0]                flash_rdata
);
   import obr_pkg::*;

   logic [31:0] mem [0:63];
   logic [3:0]  wait_cnt;
   logic        served;

   ////////////////////////////////////////////////////////////////////////////
   // sector decode: page n start at 8n, end at 8n+4, version word at 0x80
   wire  [31:0] ofs = flash_out.addr - BASE;
   wire         hit = (ofs < 32'h0000_0100);
   wire  [3:0]  lat = slow ? 4'h4 : 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // one pulse per held request; data lines toggle outside the answer cycle
   // so a reader that samples late sees an inverted word, not the answer
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         flash_ack   <= 1'b0;
         flash_rdata <= 32'h0;
         wait_cnt    <= 4'h0;
         served      <= 1'b0;
      end else begin
         flash_ack   <= 1'b0;
         flash_rdata <= ~flash_rdata;
         if (!flash_out.req) begin
            served   <= 1'b0;
            wait_cnt <= 4'h0;
         end else if (!served && wait_cnt < lat) begin
            wait_cnt <= wait_cnt + 4'h1;
         end else if (!served) begin
            served    <= 1'b1;
            flash_ack <= 1'b1;
            if (hit) begin
               flash_rdata <= mem[ofs[7:2]];
            end
            if (flash_out.we && hit) begin
               mem[ofs[7:2]] <= flash_out.wdata;
            end
         end
      end
   end
endmodule

// ### testbench/tb_obr_reader.sv
// testbench for the option-bits reader: register-port tests against a flash model.
// assumes the flash model preloaded through its memory array while idle.
module tb_obr_reader;
   timeunit 1ns;
   timeprecision 1ps;
   import obr_pkg::*;

   // option sector sits in a gap that no page covers
   localparam logic [31:0] OPT_BASE = 32'h0200_0000;

   logic                   clock;
   logic                   rst_b;
   logic                   reg_wr;
   logic                   reg_rd;
   logic                   slow;
   logic                   flash_ack;
   logic                   cfg_go;
   logic                   irq;
   logic [7:0]             reg_addr;
   logic [31:0]            reg_wdata;
   logic [31:0]            reg_rdata;
   logic [31:0]            flash_rdata;
   obr_flash_req_type      flash_out;
   logic [FULL_ADDR_W-1:0] cfg_start;
   logic [FULL_ADDR_W-1:0] cfg_end;
   logic [31:0]            st_w [0:7];
   logic [31:0]            en_w [0:7];
   int                     n_fail;
   int                     checked;

   obr_reader obr_reader_i (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .flash_out(flash_out), .flash_ack(flash_ack), .flash_rdata(flash_rdata),
      .cfg_go(cfg_go), .cfg_start(cfg_start), .cfg_end(cfg_end), .irq(irq));

   obr_flash_model #(.BASE(OPT_BASE)) obr_flash_model_i (.clock(clock), .rst_b(rst_b),
      .flash_out(flash_out), .slow(slow), .flash_ack(flash_ack), .flash_rdata(flash_rdata));

   ////////////////////////////////////////////////////////////////////////////
   // clock at 25 MHz
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparison and register-port tasks
   task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd_reg(a, d);
      chk(what, {2'b00, exp}, {2'b00, d});
   endtask

   // poll busy under a bound; a hang counts as a mismatch
   task automatic wait_idle();
      logic [31:0] d;
      d = 32'h1;
      for (int i = 0; i < 300 && d[0] !== 1'b0; i++) rd_reg(REG_STATUS, d);
      chk("busy", 34'h0, {33'h0, d[0]});
   endtask

   // select page p; cfg_go within ten cycles or a page-error event
   task automatic sel(input int p, input logic go);
      logic got;
      got = 1'b0;
      wr(REG_IRQ_CLR, 32'h0000_000F);
      wr(REG_CTRL, 32'h2 | (p << CTRL_PAGE_LSB));
      repeat (10) begin
         @(negedge clock);
         if (cfg_go === 1'b1) begin
            got = 1'b1;
            chk("cfg_start", {st_w[p][31:11], 13'h0}, cfg_start);
            chk("cfg_end", {en_w[p], 2'b11}, cfg_end);
         end
      end
      chk("cfg_go", {33'h0, go}, {33'h0, got});
      rd_chk("page error event", REG_IRQ_STAT, go ? 32'h0 : 32'h4);
      if (go) rd_chk("sel start", REG_SEL_START, {st_w[p][29:11], 13'h0});
      if (go) rd_chk("sel end", REG_SEL_END, {en_w[p][29:0], 2'b11});
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs well under 20000 cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; slow = 1'b0;
      reg_addr = 8'h00; reg_wdata = 32'h0; n_fail = 0; checked = 0;
      // page table: page 1 and 6 flagged as errors, page 2 with reserved bits set
      st_w[0] = 32'h0000_4000; en_w[0] = 32'h0019_6E30;
      st_w[1] = 32'h001C_0001; en_w[1] = 32'h0035_2E30;
      st_w[2] = 32'h0020_07FE; en_w[2] = 32'h0040_0000;
      for (int i = 3; i < 8; i++) begin
         st_w[i] = (i << 22) | ((i == 6) ? 32'h1 : 32'h0);
         en_w[i] = (i << 22) | 32'h000F_FFFF;
      end
      st_w[7] = 32'hFFFF_F800; en_w[7] = 32'hFFFF_FFFF;
      for (int i = 0; i < 64; i++) obr_flash_model_i.mem[i] = 32'hFFFF_FFFF;
      for (int i = 0; i < 8; i++) begin
         obr_flash_model_i.mem[2*i]   = st_w[i];
         obr_flash_model_i.mem[2*i+1] = en_w[i];
      end
      obr_flash_model_i.mem[32] = 32'hA5A5_A505;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;

      rd_chk("opt base reset", REG_OPT_BASE, OPT_BASE_RESET);
      rd_chk("irq en reset", REG_IRQ_EN, 32'h0);
      rd_chk("status reset", REG_STATUS, 32'h0);
      rd_chk("unmapped", 8'h20, 32'h0);
      $display("test reset done");

      wr(REG_IRQ_EN, 32'h0000_000F);
      sel(0, 1'b0);
      chk("irq on error", 34'h1, {33'h0, irq});
      wr(REG_IRQ_CLR, 32'h0000_000F);
      wr(REG_CTRL, 32'h0000_0014);
      wait_idle();
      rd_chk("mark unloaded", REG_IRQ_STAT, 32'h4);
      wr(REG_OPT_BASE, OPT_BASE | 32'h0000_1345);
      rd_chk("opt base", REG_OPT_BASE, OPT_BASE);
      $display("test unloaded and base done");

      wr(REG_IRQ_CLR, 32'h0000_000F);
      slow <= 1'b1;
      wr(REG_CTRL, 32'h1);
      wait_idle();
      rd_chk("scan events", REG_IRQ_STAT, 32'h1);
      rd_chk("status loaded", REG_STATUS, 32'h0005_BD06);
      chk("irq scan", 34'h1, {33'h0, irq});
      $display("test scan done");

      slow <= 1'b0;
      for (int p = 0; p < 8; p++) sel(p, ~st_w[p][0]);
      rd_chk("status high bits", REG_STATUS, 32'h0F05_BD06);
      rd_chk("ctrl page", REG_CTRL, 32'h0000_0070);
      $display("test select done");

      wr(REG_CTRL, 32'h4 | (1 << CTRL_PAGE_LSB));
      wait_idle();
      chk("marked word", {2'b00, st_w[1] & 32'hFFFF_FFFE},
          {2'b00, obr_flash_model_i.mem[2]});
      rd_chk("mark event", REG_IRQ_STAT, 32'h8);
      st_w[1] = st_w[1] & 32'hFFFF_FFFE;
      sel(1, 1'b1);
      $display("test mark done");

      sel(6, 1'b0);
      wr(REG_IRQ_EN, 32'h0);
      repeat (2) @(negedge clock);
      chk("irq masked", 34'h0, {33'h0, irq});
      wr(REG_IRQ_EN, 32'h0000_0004);
      repeat (2) @(negedge clock);
      chk("irq enabled", 34'h1, {33'h0, irq});
      wr(REG_IRQ_CLR, 32'h0000_0004);
      repeat (2) @(negedge clock);
      chk("irq cleared", 34'h0, {33'h0, irq});
      $display("test interrupt done");

      obr_flash_model_i.mem[32] = 32'h0000_0004;
      wr(REG_IRQ_EN, 32'h0000_000F);
      // all three command bits at once: the scan must win
      wr(REG_CTRL, 32'h7);
      wait_idle();
      rd_chk("version events", REG_IRQ_STAT, 32'h3);
      rd_chk("status bad version", REG_STATUS, 32'h0004_BF02);
      $display("test version done");
      print_verdict();
   end
endmodule
